// >>> hw/dss_core.sv
// Dual-slope converter sequencer, reading latch, display drive, AXI4-Lite
`timescale 1ns/1ps
`include "dss_defines.svh"

// Function
// R1: The oscillator clock is divided by four to make the count tick.
// R2: Signal integrate lasts exactly 1000 counts every cycle.
// R3: De-integrate runs 0 to 2000 counts, ends at zero crossing; count is the reading.
// R4: Auto-zero takes all counts de-integrate leaves, 1000 to 3000 counts.
// R5: Every full cycle is 4000 counts, 16000 oscillator clocks.
// R6: A de-integrate count of 2000 is full scale.
// R7: In liquid-crystal mode the backplane is a square wave of clock/800.
// R8: Segments toggle with the backplane, in phase when off, inverted when on.
// R9: In light-emitting mode there is no backplane and segments sink statically.
// R10: The polarity indicator is lit for negative inputs only; the code also lights it while lamp test is high.
// R11: Phases repeat auto-zero, signal integrate, de-integrate, auto-zero.
// R12: Comparator sampled at end of integrate sets reference polarity and sign.
// R13: Lamp test held high lights every segment, showing 1888; the code also lights the sign, so the display reads -1888.
// R14: Over-range shows the leading one and blanks the three low digits.
// R15: Count and polarity are latched for display at the end of de-integrate.
// R16: No crossing by the end of the window ends de-integrate with over-range.
module dss_core (
  input wire logic ref_clk_i, // Oscillator clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic comp_i, // Comparator, high while integrator positive
  input wire logic lamp_test_i, // Lamp test pin
  output dss_pkg::dss_phase_e phase_o, // Current converter phase
  output logic ref_neg_o, // Reference connection for negative input
  output logic backplane_drive_o, // Backplane square wave
  output dss_pkg::dss_disp_s seg_o, // Segment outputs
  output logic irq_o, // Interrupt, level
  input wire logic [7:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i, // Write address valid
  output logic s_axi_awready_o, // Write address ready
  input wire logic [31:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i, // Write strobes
  input wire logic s_axi_wvalid_i, // Write data valid
  output logic s_axi_wready_o, // Write data ready
  output logic [1:0] s_axi_bresp_o, // Write response
  output logic s_axi_bvalid_o, // Write response valid
  input wire logic s_axi_bready_i, // Write response ready
  input wire logic [7:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i, // Read address valid
  output logic s_axi_arready_o, // Read address ready
  output logic [31:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o, // Read response
  output logic s_axi_rvalid_o, // Read data valid
  input wire logic s_axi_rready_i // Read data ready
);
  import dss_pkg::*;

  function automatic logic [6:0] seg7(input logic [3:0] bcd);
    logic [6:0] s;
    s = 7'h00;
    case (bcd)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      default: s = 7'h00;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic comp_m_reg, comp_s_reg, lamp_m_reg, lamp_s_reg;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      comp_m_reg <= 1'b0;
      comp_s_reg <= 1'b0;
      lamp_m_reg <= 1'b0;
      lamp_s_reg <= 1'b0;
    end else begin
      comp_m_reg <= comp_i;
      comp_s_reg <= comp_m_reg;
      lamp_m_reg <= lamp_test_i;
      lamp_s_reg <= lamp_m_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers seen by software
  logic [1:0] ctrl_reg, status_reg, mask_reg;
  wire run_w = ctrl_reg[`DSS_CTRL_RUN_BIT];
  wire lcd_w = ctrl_reg[`DSS_CTRL_LCD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and phase sequencer
  logic [1:0] pre_reg;
  dss_phase_e phase_reg;
  logic [11:0] cnt_reg, az_len_reg;
  logic pos_reg;
  logic [3:0] bcd_reg [0:2];
  logic thou_reg;
  wire tick_w = run_w && (pre_reg == `DSS_PRESCALE_LAST); // R1
  wire int_end_w = (phase_reg == DSS_SIG_INT) &&
                   (cnt_reg == `DSS_INT_COUNTS - 12'h001); // R2
  wire az_end_w = (phase_reg == DSS_AUTO_ZERO) &&
                  (cnt_reg == az_len_reg - 12'h001); // R4
  wire cross_w = (phase_reg == DSS_DEINT) && (comp_s_reg != pos_reg); // R3
  wire de_full_w = (phase_reg == DSS_DEINT) &&
                   (cnt_reg == `DSS_DE_COUNTS - 12'h001); // R16
  wire de_end_w = cross_w || de_full_w;
  wire [11:0] az_next_w = `DSS_AZ_BASE - cnt_reg; // R4 R5

  // Decade counters: each digit carries into the next at nine
  wire [3:0] carry_w;
  assign carry_w[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dec
      assign carry_w[gi+1] = carry_w[gi] && (bcd_reg[gi] == 4'h9);
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          bcd_reg[gi] <= 4'h0;
        end else if (tick_w && int_end_w) begin
          bcd_reg[gi] <= 4'h0;
        end else if (tick_w && phase_reg == DSS_DEINT && !de_end_w &&
                     carry_w[gi]) begin
          bcd_reg[gi] <= carry_w[gi+1] ? 4'h0 : bcd_reg[gi] + 4'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_reg <= 2'h0;
      phase_reg <= DSS_AUTO_ZERO;
      cnt_reg <= 12'h000;
      az_len_reg <= `DSS_AZ_FIRST;
      pos_reg <= 1'b1;
      thou_reg <= 1'b0;
    end else begin
      if (run_w) begin
        pre_reg <= pre_reg + 2'h1;
      end
      if (tick_w) begin
        cnt_reg <= cnt_reg + 12'h001;
        case (phase_reg)
          DSS_AUTO_ZERO: begin
            if (az_end_w) begin
              phase_reg <= DSS_SIG_INT; // R11
              cnt_reg <= 12'h000;
            end
          end
          DSS_SIG_INT: begin
            if (int_end_w) begin
              phase_reg <= DSS_DEINT; // R11
              cnt_reg <= 12'h000;
              pos_reg <= comp_s_reg; // R12
              thou_reg <= 1'b0;
            end
          end
          DSS_DEINT: begin
            if (de_end_w) begin
              phase_reg <= DSS_AUTO_ZERO; // R11
              cnt_reg <= 12'h000;
              az_len_reg <= az_next_w; // R4 R5
            end else if (carry_w[3]) begin
              thou_reg <= 1'b1;
            end
          end
          default: begin
            phase_reg <= DSS_AUTO_ZERO;
            cnt_reg <= 12'h000;
          end
        endcase
      end
    end
  end
  wire de_done_w = tick_w && de_end_w;

  ////////////////////////////////////////////////////////////////////////////
  // Reading latch
  logic [3:0] disp_bcd_reg [0:2];
  logic disp_thou_reg, disp_neg_reg, disp_ovr_reg;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 3; i++) begin
        disp_bcd_reg[i] <= 4'h0;
      end
      disp_thou_reg <= 1'b0;
      disp_neg_reg <= 1'b0;
      disp_ovr_reg <= 1'b0;
    end else if (de_done_w) begin
      for (int i = 0; i < 3; i++) begin
        disp_bcd_reg[i] <= bcd_reg[i]; // R15
      end
      disp_thou_reg <= thou_reg; // R15
      disp_neg_reg <= !pos_reg; // R10
      disp_ovr_reg <= !cross_w; // R6 R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment and backplane drive
  logic [8:0] bp_cnt_reg;
  logic bp_reg, ref_neg_reg, irq_reg;
  dss_disp_s seg_reg;
  wire bp_wrap_w = (bp_cnt_reg == `DSS_BP_HALF - 9'h001);
  wire bp_next_w = lcd_w ? (bp_reg ^ bp_wrap_w) : 1'b0; // R7 R9
  wire dss_disp_s on_w;
  assign on_w.sign_on = lamp_s_reg || disp_neg_reg; // R10 R13
  assign on_w.thousand_on = lamp_s_reg || disp_thou_reg ||
                            disp_ovr_reg; // R13 R14
  generate
    for (gi = 0; gi < 3; gi++) begin : g_seg
      assign on_w.digit_seg[gi*7 +: 7] = lamp_s_reg ? 7'h7f : // R13
        (disp_ovr_reg ? 7'h00 : seg7(disp_bcd_reg[gi])); // R14
    end
  endgenerate
  wire [22:0] seg_next_w = lcd_w ? (on_w ^ {23{bp_next_w}}) : on_w; // R8 R9

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bp_cnt_reg <= 9'h000;
      bp_reg <= 1'b0;
      seg_reg <= '0;
      ref_neg_reg <= 1'b0;
    end else begin
      bp_cnt_reg <= bp_wrap_w ? 9'h000 : bp_cnt_reg + 9'h001; // R7
      bp_reg <= bp_next_w;
      seg_reg <= seg_next_w;
      ref_neg_reg <= !pos_reg; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  wire aw_hs_w = s_axi_awvalid_i && awready_reg;
  wire w_hs_w = s_axi_wvalid_i && wready_reg;
  wire do_wr_w = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_ctrl_w = do_wr_w && awaddr_reg == `DSS_CTRL_OFS && wstrb_reg[0];
  wire wr_st_w = do_wr_w && awaddr_reg == `DSS_STATUS_OFS && wstrb_reg[0];
  wire wr_mask_w = do_wr_w && awaddr_reg == `DSS_MASK_OFS && wstrb_reg[0];
  wire wr_hit_w = awaddr_reg == `DSS_CTRL_OFS ||
                  awaddr_reg == `DSS_STATUS_OFS ||
                  awaddr_reg == `DSS_MASK_OFS ||
                  awaddr_reg == `DSS_READING_OFS;
  wire [31:0] reading_w = {14'h0000, phase_reg, 1'b0, disp_ovr_reg,
                           disp_neg_reg, disp_thou_reg, disp_bcd_reg[2],
                           disp_bcd_reg[1], disp_bcd_reg[0]};
  wire rd_hit_w = s_axi_araddr_i == `DSS_CTRL_OFS ||
                  s_axi_araddr_i == `DSS_STATUS_OFS ||
                  s_axi_araddr_i == `DSS_MASK_OFS ||
                  s_axi_araddr_i == `DSS_READING_OFS;
  wire [31:0] rd_mux_w =
    (s_axi_araddr_i == `DSS_CTRL_OFS) ? {30'h0, ctrl_reg} :
    (s_axi_araddr_i == `DSS_STATUS_OFS) ? {30'h0, status_reg} :
    (s_axi_araddr_i == `DSS_MASK_OFS) ? {30'h0, mask_reg} :
    (s_axi_araddr_i == `DSS_READING_OFS) ? reading_w : 32'h00000000;
  // Hardware set wins over a write-one clear in the same cycle
  wire [1:0] st_set_w = {de_done_w && !cross_w, de_done_w};
  wire [1:0] st_clr_w = wr_st_w ? wdata_reg[1:0] : 2'h0;
  wire [1:0] status_next_w = (status_reg & ~st_clr_w) | st_set_w;
  wire [1:0] mask_next_w = wr_mask_w ? wdata_reg[1:0] : mask_reg;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DSS_RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `DSS_RESP_OKAY;
      ctrl_reg <= `DSS_CTRL_RESET;
      status_reg <= 2'h0;
      mask_reg <= `DSS_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      if (aw_hs_w) begin
        awready_reg <= 1'b0;
        awaddr_reg <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (w_hs_w) begin
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (do_wr_w) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit_w ? `DSS_RESP_OKAY : `DSS_RESP_DECERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
      if (s_axi_arvalid_i && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux_w;
        rresp_reg <= rd_hit_w ? `DSS_RESP_OKAY : `DSS_RESP_DECERR;
      end else if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
      if (wr_ctrl_w) begin
        ctrl_reg <= wdata_reg[1:0];
      end
      status_reg <= status_next_w;
      mask_reg <= mask_next_w;
      irq_reg <= |(status_next_w & mask_next_w);
    end
  end

  assign phase_o = phase_reg;
  assign ref_neg_o = ref_neg_reg;
  assign backplane_drive_o = bp_reg;
  assign seg_o = seg_reg;
  assign irq_o = irq_reg;
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [12:0] cyc_ticks_reg;
  logic cyc_seen_reg;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cyc_ticks_reg <= 13'h0000;
      cyc_seen_reg <= 1'b0;
    end else if (tick_w) begin
      if (az_end_w) begin
        cyc_ticks_reg <= 13'h0001;
        cyc_seen_reg <= 1'b1;
      end else begin
        cyc_ticks_reg <= cyc_ticks_reg + 13'h0001;
      end
    end
  end

  a_tick_spacing: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R1
    tick_w |=> !tick_w [*3] ##1 (tick_w || !run_w))
    else $error("count tick not every fourth clock");
  a_int_length: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R2
    (tick_w && int_end_w) |-> cyc_ticks_reg == 13'h03e8)
    else $error("integrate not 1000 counts");
  a_de_window: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R3
    phase_reg == DSS_DEINT |-> cnt_reg < 12'h7d0)
    else $error("de-integrate past 2000 counts");
  a_cycle_length: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R5
    (tick_w && az_end_w && cyc_seen_reg) |-> cyc_ticks_reg == 13'h0fa0)
    else $error("cycle not 4000 counts");
  a_az_range: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R4
    az_len_reg >= 12'h3e8 && az_len_reg <= 12'hbb8)
    else $error("auto-zero length out of range");
  a_phase_order: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R11
    (phase_reg != $past(phase_reg)) |->
      (phase_reg == DSS_SIG_INT && $past(phase_reg) == DSS_AUTO_ZERO) ||
      (phase_reg == DSS_DEINT && $past(phase_reg) == DSS_SIG_INT) ||
      (phase_reg == DSS_AUTO_ZERO && $past(phase_reg) == DSS_DEINT))
    else $error("phase order broken");
  a_bp_half: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R7
    (lcd_w && $changed(bp_reg) && $stable(ctrl_reg)) |->
      $past(bp_cnt_reg) == 9'h18f)
    else $error("backplane half period not 400 clocks");
  a_seg_phase: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R8
    (lcd_w && $stable(ctrl_reg)) |=> seg_o == ($past(on_w) ^ {23{bp_reg}}))
    else $error("segment phase wrong");
  a_led_static: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R9
    (!lcd_w && $stable(ctrl_reg)) |=> !backplane_drive_o &&
      seg_o == $past(on_w))
    else $error("light-emitting drive not static");
  a_over_blank: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R14
    (de_done_w && !cross_w) |=> disp_ovr_reg ##1
      (lamp_s_reg || on_w.digit_seg == 21'h000000))
    else $error("over-range digits not blanked");
  a_sign_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R10 R12
    de_done_w |=> disp_neg_reg == !$past(pos_reg))
    else $error("polarity indicator wrong");
endmodule

// >>> inc/dss_defines.svh
// Constants of the dual-slope sequencer: counts, offsets, reset values
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH
// Last prescaler state, four oscillator clocks per count (prescale by four)
`define DSS_PRESCALE_LAST 2'h3
// Signal integrate length, 1000 counts
`define DSS_INT_COUNTS 12'h3e8
// De-integrate window, 2000 counts
`define DSS_DE_COUNTS 12'h7d0
// Whole cycle, 4000 counts
`define DSS_CYCLE_COUNTS 12'hfa0
// Auto-zero base: 4000 - 1000 - 1 counts
`define DSS_AZ_BASE 12'hbb7
// Auto-zero length of the first cycle after reset, 1000 counts
`define DSS_AZ_FIRST 12'h3e8
// Backplane period 800 clocks, half period 400 clocks
`define DSS_BP_HALF 9'h190
// Register byte offsets
`define DSS_CTRL_OFS 8'h00
`define DSS_STATUS_OFS 8'h04
`define DSS_MASK_OFS 8'h08
`define DSS_READING_OFS 8'h0c
// Field positions
`define DSS_CTRL_RUN_BIT 0
`define DSS_CTRL_LCD_BIT 1
`define DSS_ST_DONE_BIT 0
`define DSS_ST_OVR_BIT 1
// Reset values
`define DSS_CTRL_RESET 2'h3
`define DSS_MASK_RESET 2'h0
`define DSS_RESP_OKAY 2'h0
`define DSS_RESP_DECERR 2'h3
`endif

// >>> inc/dss_pkg.sv
// Types of the dual-slope sequencer
package dss_pkg;
  typedef enum logic [1:0] {
    DSS_AUTO_ZERO = 2'b00,
    DSS_SIG_INT = 2'b01,
    DSS_DEINT = 2'b10
  } dss_phase_e;

  typedef struct packed {
    logic sign_on;
    logic thousand_on;
    logic [20:0] digit_seg;
  } dss_disp_s;
endpackage

// >>> test/dss_analog_model.sv
// Behavioural integrator and comparator at the far side of the sequencer
`timescale 1ns/1ps
module dss_analog_model (
  input wire logic clk_i, // Oscillator clock
  input wire dss_pkg::dss_phase_e phase_i, // Converter phase
  input wire logic ref_neg_i, // Reference polarity select
  input wire logic signed [15:0] vin_i, // Input in display counts
  output logic comp_o // High while integrator positive
);
  import dss_pkg::*;
  int acc = 0;
  initial comp_o = 1'b0;
  // Input adds vin per clock, reference removes 1000 per clock
  always @(posedge clk_i) begin
    case (phase_i)
      DSS_AUTO_ZERO: acc <= 0;
      DSS_SIG_INT: acc <= acc + vin_i;
      default: acc <= ref_neg_i ? acc + 1000 : acc - 1000;
    endcase
    comp_o <= acc > 0;
  end
endmodule

// >>> test/tb_dss_core.sv
// Self-checking bench of the dual-slope sequencer
`timescale 1ns/1ps
`include "dss_defines.svh"
module tb_dss_core;
  import dss_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    int tol;
    logic [1:0] r;
  } dss_note_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lamp = 1'b0;
  logic comp;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, irq, ref_neg, bp;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  dss_phase_e phase;
  dss_phase_e pph = DSS_AUTO_ZERO;
  dss_disp_s seg;
  logic signed [15:0] vin = 16'sh0;
  dss_note_s rq[$];
  logic [1:0] bq[$];
  dss_note_s nt;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_int = 0;
  int convs = 0;
  int dv;
  int m;
  logic [20:0] s1;
  logic [31:0] seed = 32'h2b;

  dss_core u_dss_core (
    .ref_clk_i(clk), .sys_rst_i(rst), .comp_i(comp), .lamp_test_i(lamp),
    .phase_o(phase), .ref_neg_o(ref_neg), .backplane_drive_o(bp),
    .seg_o(seg), .irq_o(irq),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready)
  );
  dss_analog_model u_dss_analog_model (
    .clk_i(clk), .phase_i(phase), .ref_neg_i(ref_neg), .vin_i(vin),
    .comp_o(comp)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int bcd(logic [31:0] v);
    return v[12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction
  function automatic logic [31:0] enc(int n, logic neg);
    return {18'h0, neg, n >= 1000, 4'(n / 100 % 10), 4'(n / 10 % 10),
      4'(n % 10)};
  endfunction
  function automatic dss_phase_e nxt(dss_phase_e p);
    case (p)
      DSS_AUTO_ZERO: return DSS_SIG_INT;
      DSS_SIG_INT: return DSS_DEINT;
      default: return DSS_AUTO_ZERO;
    endcase
  endfunction

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic timeout(string what);
    mismatches++;
    $display("unexpected %s: expected answer seen timeout", what);
    final_report();
  endtask
  task automatic clks(int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus tasks start right after an edge and end right after one
  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    int n;
    n = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      if (n > 1000) timeout("write");
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axr(logic [7:0] a, logic [31:0] d, logic [31:0] mk,
      int tol, logic [1:0] r);
    int n;
    n = 0;
    rq.push_back('{d, mk, tol, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
      if (n > 1000) timeout("read");
    end while (arvalid || rready);
  endtask
  task automatic wait_conv();
    int n;
    int c0;
    n = 0;
    c0 = convs;
    while (convs == c0) begin
      @(posedge clk);
      n++;
      if (n > 20000) timeout("conversion");
    end
  endtask
  task automatic wait_bp(logic v);
    int n;
    n = 0;
    while (bp !== v) begin
      @(posedge clk);
      n++;
      if (n > 1000) timeout("backplane");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Result watcher: bus answers, phase order and phase lengths
  always @(posedge clk) begin
    cyc++;
    if (rvalid && rready) begin
      nt = rq.pop_front();
      chk("rresp", nt.r, rresp);
      chk("rdata", nt.d & nt.m, rdata & nt.m);
      if (nt.tol > 0) begin
        dv = bcd(rdata) - bcd(nt.d);
        chk("reading", 1, dv <= nt.tol && dv >= -nt.tol);
      end
    end
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
    if (!rst && phase !== pph) begin
      chk("phase order", nxt(pph), phase);
      if (pph == DSS_SIG_INT) chk("integrate", 4 * `DSS_INT_COUNTS, cyc - t_int);
      if (phase == DSS_SIG_INT) begin
        if (t_int > 0) chk("cycle", 4 * `DSS_CYCLE_COUNTS, cyc - t_int);
        t_int = cyc;
      end
      if (pph == DSS_DEINT) convs++;
      pph = phase;
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(`DSS_CTRL_OFS, 32'(`DSS_CTRL_RESET), '1, 0, `DSS_RESP_OKAY);
    axr(`DSS_MASK_OFS, 32'(`DSS_MASK_RESET), '1, 0, `DSS_RESP_OKAY);
    axr(8'h10, 32'h0, '1, 0, `DSS_RESP_DECERR);
    axw(8'h10, 32'h3, `DSS_RESP_DECERR);
    axw(`DSS_MASK_OFS, 32'h1, `DSS_RESP_OKAY);
    m = 100 + rnd() % 1800;
    vin <= 16'(m);
    $display("test registers done");
    wait_conv();
    vin <= -16'(100 + rnd() % 1800);
    clks(4);
    chk("irq", 1, irq);
    chk("ref polarity", 0, ref_neg);
    axr(`DSS_READING_OFS, enc(m, 0), 32'h6000, 2, `DSS_RESP_OKAY);
    axw(`DSS_STATUS_OFS, 32'h1, `DSS_RESP_OKAY);
    clks(2);
    chk("irq", 0, irq);
    axr(`DSS_STATUS_OFS, 32'h0, 32'h1, 0, `DSS_RESP_OKAY);
    axw(`DSS_MASK_OFS, 32'h0, `DSS_RESP_OKAY);
    $display("test positive done");
    wait_conv();
    m = -vin;
    vin <= 16'sd2100;
    clks(4);
    chk("masked irq", 0, irq);
    chk("ref polarity", 1, ref_neg);
    axr(`DSS_STATUS_OFS, 32'h1, 32'h1, 0, `DSS_RESP_OKAY);
    axr(`DSS_READING_OFS, enc(m, 1), 32'h6000, 2, `DSS_RESP_OKAY);
    wait_bp(0);
    wait_bp(1);
    m = 0;
    while (bp === 1'b1 && m < 1000) begin
      @(posedge clk);
      m++;
    end
    chk("backplane half", `DSS_BP_HALF, m);
    clks(10);
    s1 = seg.digit_seg ^ {21{bp}};
    chk("sign", 1, seg.sign_on ^ bp);
    wait_bp(1);
    clks(10);
    chk("segments", s1, seg.digit_seg ^ {21{bp}});
    axw(`DSS_CTRL_OFS, 32'h1, `DSS_RESP_OKAY);
    $display("test negative done");
    wait_conv();
    clks(4);
    chk("led backplane", 0, bp);
    chk("over digits", 0, seg.digit_seg);
    chk("over one", 1, seg.thousand_on);
    axr(`DSS_READING_OFS, 32'h4000, 32'h6000, 0, `DSS_RESP_OKAY);
    axr(`DSS_STATUS_OFS, 32'h2, 32'h2, 0, `DSS_RESP_OKAY);
    lamp <= 1'b1;
    clks(6);
    chk("lamp led", 21'h1fffff, seg.digit_seg);
    chk("lamp one", 1, seg.thousand_on);
    axw(`DSS_CTRL_OFS, 32'h3, `DSS_RESP_OKAY);
    wait_bp(1);
    clks(10);
    chk("lamp lcd", 21'h1fffff, seg.digit_seg ^ {21{bp}});
    lamp <= 1'b0;
    $display("test over-range done");
    final_report();
  end
endmodule
